// *** shared/ptab_pkg.sv ***
package ptab_pkg;

    // ------------------------------------------------------------
    // register port
    // ------------------------------------------------------------
    localparam int BUS_ADDR_W = 8;
    localparam int BUS_ADDR_MIN = 5;
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_PTR = 8'h04;
    localparam logic [7:0] REG_DATA = 8'h08;
    localparam logic [7:0] REG_DWORD = 8'h0C;
    localparam logic [7:0] REG_STATUS = 8'h10;
    localparam logic [7:0] REG_WALK = 8'h14;
    localparam logic [31:0] READ_UNMAPPED = 32'h0000_0000;

    // ctrl fields
    localparam int CTRL_SPACE_BIT = 0;
    localparam int CTRL_AUTOINC_BIT = 1;
    localparam int CTRL_WALK_BIT = 2;
    localparam logic CTRL_SPACE_RST = 1'b0;
    localparam logic CTRL_AUTOINC_RST = 1'b1;

    // status fields
    localparam int ST_REFUSED_BIT = 0;
    localparam int ST_BUSY_BIT = 1;
    localparam int ST_DONE_BIT = 2;
    localparam int ST_OVERRUN_BIT = 3;

    // walk result fields
    localparam int WALK_PARAMS_LSB = 0;
    localparam int WALK_PADS_LSB = 8;
    localparam int WALK_LOC_LSB = 16;
    localparam int WALK_MAX_PARAMS = 16;
    localparam int WALK_MAX_LIMIT = 255;

    // ------------------------------------------------------------
    // parameter map
    // ------------------------------------------------------------
    localparam logic [7:0] ID_PAD = 8'hF0;
    localparam logic [7:0] ID_SFDP = 8'hA5;
    localparam logic [7:0] FILL = 8'hFF;
    localparam logic [7:0] LEN_PAD0 = 8'h0F;
    localparam logic [7:0] LEN_PAD1 = 8'h01;
    localparam logic [7:0] LEN_SFDP = 8'h50;
    localparam logic [15:0] REL_ID = 16'h0000;
    localparam logic [15:0] REL_LEN = 16'h0001;
    localparam logic [15:0] PARAM_HDR = 16'h0002;
    localparam logic [15:0] PAD0_BASE = 16'h0000;
    localparam logic [15:0] PAD1_BASE = PAD0_BASE + 16'(LEN_PAD0) + PARAM_HDR;
    localparam logic [15:0] SFDP_BASE = PAD1_BASE + 16'(LEN_PAD1) + PARAM_HDR;
    localparam logic [15:0] MAP_END = SFDP_BASE + 16'(LEN_SFDP) + PARAM_HDR;

    // ------------------------------------------------------------
    // basic flash parameter table
    // ------------------------------------------------------------
    localparam logic [15:0] TABLE_ADDR = 16'h1120;
    localparam logic [15:0] TABLE_LEN = 16'h0008;
    localparam logic [7:0] TBL_BYTE0 = 8'hE7;
    localparam logic [7:0] TBL_BYTE1 = 8'hFF;
    localparam logic [7:0] TBL_BYTE2 = 8'hEA;
    localparam int TBL_DDR_BIT = 3;
    localparam logic [7:0] TBL_BYTE3 = 8'hFF;
    localparam logic [31:0] DENSITY_M1 = 32'h3FFF_FFFF;
    localparam logic DDR_SUPPORT_DEF = 1'b1;

endpackage

// *** hw/ptab_rom.sv ***
module ptab_rom #(
    parameter int LANES = 1,
    parameter bit DDR_SUPPORT = ptab_pkg::DDR_SUPPORT_DEF
) (
    // lookup
    input wire logic space_sel,
    input wire logic [15:0] base,
    output logic [8*LANES-1:0] bytes
);

    // ------------------------------------------------------------
    // fixed contents
    // ------------------------------------------------------------
    function automatic logic [7:0] table_byte(input logic [15:0] idx);
        case (idx)
            16'h0000: table_byte = ptab_pkg::TBL_BYTE0;
            16'h0001: table_byte = ptab_pkg::TBL_BYTE1;
            16'h0002: begin
                table_byte = ptab_pkg::TBL_BYTE2;
                table_byte[ptab_pkg::TBL_DDR_BIT] = DDR_SUPPORT;
            end
            16'h0003: table_byte = ptab_pkg::TBL_BYTE3;
            16'h0004: table_byte = ptab_pkg::DENSITY_M1[7:0];
            16'h0005: table_byte = ptab_pkg::DENSITY_M1[15:8];
            16'h0006: table_byte = ptab_pkg::DENSITY_M1[23:16];
            16'h0007: table_byte = ptab_pkg::DENSITY_M1[31:24];
            default: table_byte = ptab_pkg::FILL;
        endcase
    endfunction

    function automatic logic [7:0] param_byte(input logic [15:0] rel,
                                              input logic [7:0] id,
                                              input logic [7:0] len);
        if (rel == ptab_pkg::REL_ID) begin
            param_byte = id;
        end else if (rel == ptab_pkg::REL_LEN) begin
            param_byte = len;
        end else begin
            param_byte = ptab_pkg::FILL;
        end
    endfunction

    function automatic logic [7:0] map_byte(input logic [15:0] a);
        logic [15:0] rel;
        rel = a - ptab_pkg::SFDP_BASE;
        if (a < ptab_pkg::PAD1_BASE) begin
            map_byte = param_byte(a - ptab_pkg::PAD0_BASE, ptab_pkg::ID_PAD, ptab_pkg::LEN_PAD0);
        end else if (a < ptab_pkg::SFDP_BASE) begin
            map_byte = param_byte(a - ptab_pkg::PAD1_BASE, ptab_pkg::ID_PAD, ptab_pkg::LEN_PAD1);
        end else if (a < ptab_pkg::MAP_END) begin
            if (rel >= ptab_pkg::PARAM_HDR && rel < ptab_pkg::PARAM_HDR + ptab_pkg::TABLE_LEN) begin
                map_byte = table_byte(rel - ptab_pkg::PARAM_HDR);
            end else begin
                map_byte = param_byte(rel, ptab_pkg::ID_SFDP, ptab_pkg::LEN_SFDP);
            end
        end else begin
            map_byte = ptab_pkg::FILL;
        end
    endfunction

    function automatic logic [7:0] sfdp_byte(input logic [15:0] a);
        logic [15:0] idx;
        idx = a - ptab_pkg::TABLE_ADDR;
        if (a >= ptab_pkg::TABLE_ADDR && idx < ptab_pkg::TABLE_LEN) begin
            sfdp_byte = table_byte(idx);
        end else begin
            sfdp_byte = ptab_pkg::FILL;
        end
    endfunction

    // ------------------------------------------------------------
    // lanes in ascending address order
    // ------------------------------------------------------------
    always_comb begin
        for (int i = 0; i < LANES; i++) begin
            if (space_sel) begin
                bytes[8*i +: 8] = sfdp_byte(base + 16'(i));
            end else begin
                bytes[8*i +: 8] = map_byte(base + 16'(i));
            end
        end
    end

endmodule // ptab_rom

// *** hw/flash_parameter_table_rom.sv ***
module flash_parameter_table_rom #(
    parameter int ADDR_W = ptab_pkg::BUS_ADDR_W,
    parameter int WALK_MAX = ptab_pkg::WALK_MAX_PARAMS,
    parameter bit DDR_SUPPORT = ptab_pkg::DDR_SUPPORT_DEF
) (
    // clock and reset
    input wire logic clock,
    input wire logic reset,
    // register port
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [31:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [31:0] rd_data
);

    // ------------------------------------------------------------
    // parameter checks
    // ------------------------------------------------------------
    if (ADDR_W < ptab_pkg::BUS_ADDR_MIN) begin : g_bad_addr_w
        $error("ADDR_W too small for the register map");
    end
    if (WALK_MAX < 1 || WALK_MAX > ptab_pkg::WALK_MAX_LIMIT) begin : g_bad_walk_max
        $error("WALK_MAX out of range");
    end

    localparam logic [7:0] WALK_LIMIT = 8'(WALK_MAX);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
        hit = (a == ADDR_W'(off));
    endfunction

    function automatic logic [15:0] advance(input logic [15:0] p, input logic [15:0] step);
        advance = p + step;
    endfunction

    typedef enum logic [1:0] {
        WALK_IDLE,
        WALK_SCAN,
        WALK_FINISH
    } walk_state_t;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic space_q;
    logic autoinc_q;
    logic [15:0] ptr_q;
    logic [31:0] rd_data_q;
    logic refused_q;
    logic overrun_q;
    logic done_q;
    walk_state_t walk_q;
    walk_state_t walk_d;
    logic [15:0] cursor_q;
    logic [7:0] param_cnt_q;
    logic [7:0] pad_cnt_q;
    logic [15:0] sfdp_loc_q;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    logic wr_ctrl;
    logic wr_ptr;
    logic wr_status;
    logic wr_table;
    logic wr_unmapped;
    logic rd_byte;
    logic rd_dword;
    logic walk_start;
    logic walk_step;
    logic walk_stop;
    logic [31:0] lane_bytes;
    logic [15:0] walk_bytes;
    logic [7:0] walk_id;
    logic [7:0] walk_len;
    logic [15:0] ptr_limit;
    logic past_end;

    assign wr_ctrl = wr_en && hit(addr, ptab_pkg::REG_CTRL);
    assign wr_ptr = wr_en && hit(addr, ptab_pkg::REG_PTR);
    assign wr_status = wr_en && hit(addr, ptab_pkg::REG_STATUS);
    assign wr_table = wr_en && (hit(addr, ptab_pkg::REG_DATA) || hit(addr, ptab_pkg::REG_DWORD));
    assign wr_unmapped = wr_en && !wr_ctrl && !wr_ptr && !wr_status && !wr_table
                         && !hit(addr, ptab_pkg::REG_WALK);
    assign rd_byte = rd_en && hit(addr, ptab_pkg::REG_DATA);
    assign rd_dword = rd_en && hit(addr, ptab_pkg::REG_DWORD);
    assign walk_start = wr_ctrl && wr_data[ptab_pkg::CTRL_WALK_BIT] && (walk_q == WALK_IDLE);

    // ------------------------------------------------------------
    // table lookups
    // ------------------------------------------------------------
    ptab_rom #(
        .LANES(4),
        .DDR_SUPPORT(DDR_SUPPORT)
    ) u_read_rom (
        .space_sel(space_q),
        .base(ptr_q),
        .bytes(lane_bytes)
    );

    // walker always follows the parameter chain, never the table space
    ptab_rom #(
        .LANES(2),
        .DDR_SUPPORT(DDR_SUPPORT)
    ) u_walk_rom (
        .space_sel(1'b0),
        .base(cursor_q),
        .bytes(walk_bytes)
    );

    assign walk_id = walk_bytes[7:0];
    assign walk_len = walk_bytes[15:8];

    // ------------------------------------------------------------
    // control register
    // ------------------------------------------------------------
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            space_q <= ptab_pkg::CTRL_SPACE_RST;
            autoinc_q <= ptab_pkg::CTRL_AUTOINC_RST;
        end else if (wr_ctrl) begin
            space_q <= wr_data[ptab_pkg::CTRL_SPACE_BIT];
            autoinc_q <= wr_data[ptab_pkg::CTRL_AUTOINC_BIT];
        end
    end

    // ------------------------------------------------------------
    // read pointer
    // ------------------------------------------------------------
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            ptr_q <= 16'h0000;
        end else if (wr_ptr) begin
            ptr_q <= wr_data[15:0];
        end else if (wr_ctrl && (wr_data[ptab_pkg::CTRL_SPACE_BIT] != space_q)) begin
            // a new space starts at its own base
            ptr_q <= wr_data[ptab_pkg::CTRL_SPACE_BIT] ? ptab_pkg::TABLE_ADDR : ptab_pkg::PAD0_BASE;
        end else if (rd_byte && autoinc_q) begin
            ptr_q <= advance(ptr_q, 16'h0001);
        end else if (rd_dword && autoinc_q) begin
            ptr_q <= advance(ptr_q, 16'h0004);
        end
    end

    // ------------------------------------------------------------
    // overrun flag: a read left the populated part of the space
    // ------------------------------------------------------------
    assign ptr_limit = space_q ? (ptab_pkg::TABLE_ADDR + ptab_pkg::TABLE_LEN) : ptab_pkg::MAP_END;
    assign past_end = (rd_byte && (ptr_q >= ptr_limit))
                      || (rd_dword && (advance(ptr_q, 16'h0003) >= ptr_limit))
                      || (space_q && (rd_byte || rd_dword) && (ptr_q < ptab_pkg::TABLE_ADDR));

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            overrun_q <= 1'b0;
        end else if (past_end) begin
            overrun_q <= 1'b1;
        end else if (wr_status && wr_data[ptab_pkg::ST_OVERRUN_BIT]) begin
            overrun_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // refused writes: contents are fixed
    // ------------------------------------------------------------
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            refused_q <= 1'b0;
        end else if (wr_table || wr_unmapped) begin
            refused_q <= 1'b1;
        end else if (wr_status && wr_data[ptab_pkg::ST_REFUSED_BIT]) begin
            refused_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // chain walker
    // ------------------------------------------------------------
    assign walk_stop = (walk_id == ptab_pkg::FILL) || (param_cnt_q == WALK_LIMIT);
    assign walk_step = (walk_q == WALK_SCAN) && !walk_stop;

    always_comb begin
        walk_d = walk_q;
        case (walk_q)
            WALK_IDLE: begin
                if (walk_start) begin
                    walk_d = WALK_SCAN;
                end
            end
            WALK_SCAN: begin
                if (walk_stop) begin
                    walk_d = WALK_FINISH;
                end
            end
            WALK_FINISH: begin
                walk_d = WALK_IDLE;
            end
            default: begin
                walk_d = WALK_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            walk_q <= WALK_IDLE;
        end else begin
            walk_q <= walk_d;
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            cursor_q <= ptab_pkg::PAD0_BASE;
        end else if (walk_start) begin
            cursor_q <= ptab_pkg::PAD0_BASE;
        end else if (walk_step) begin
            // length byte sits at cursor + 1; next starts len + 1 past it
            cursor_q <= advance(cursor_q, ptab_pkg::PARAM_HDR + 16'(walk_len));
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            param_cnt_q <= 8'h00;
            pad_cnt_q <= 8'h00;
        end else if (walk_start) begin
            param_cnt_q <= 8'h00;
            pad_cnt_q <= 8'h00;
        end else if (walk_step) begin
            param_cnt_q <= param_cnt_q + 8'h01;
            if (walk_id == ptab_pkg::ID_PAD) begin
                pad_cnt_q <= pad_cnt_q + 8'h01;
            end
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            sfdp_loc_q <= 16'hFFFF;
        end else if (walk_start) begin
            sfdp_loc_q <= 16'hFFFF;
        end else if (walk_step && (walk_id == ptab_pkg::ID_SFDP)) begin
            sfdp_loc_q <= cursor_q;
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            done_q <= 1'b0;
        end else if (walk_q == WALK_FINISH) begin
            done_q <= 1'b1;
        end else if (walk_start) begin
            done_q <= 1'b0;
        end else if (wr_status && wr_data[ptab_pkg::ST_DONE_BIT]) begin
            done_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // read data, one cycle after the strobe
    // ------------------------------------------------------------
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            rd_data_q <= 32'h0000_0000;
        end else if (rd_en) begin
            rd_data_q <= ptab_pkg::READ_UNMAPPED;
            if (hit(addr, ptab_pkg::REG_CTRL)) begin
                rd_data_q[ptab_pkg::CTRL_SPACE_BIT] <= space_q;
                rd_data_q[ptab_pkg::CTRL_AUTOINC_BIT] <= autoinc_q;
            end else if (hit(addr, ptab_pkg::REG_PTR)) begin
                rd_data_q[15:0] <= ptr_q;
            end else if (rd_byte) begin
                rd_data_q[7:0] <= lane_bytes[7:0];
            end else if (rd_dword) begin
                rd_data_q <= lane_bytes;
            end else if (hit(addr, ptab_pkg::REG_STATUS)) begin
                rd_data_q[ptab_pkg::ST_REFUSED_BIT] <= refused_q;
                rd_data_q[ptab_pkg::ST_BUSY_BIT] <= (walk_q != WALK_IDLE);
                rd_data_q[ptab_pkg::ST_DONE_BIT] <= done_q;
                rd_data_q[ptab_pkg::ST_OVERRUN_BIT] <= overrun_q;
            end else if (hit(addr, ptab_pkg::REG_WALK)) begin
                rd_data_q[ptab_pkg::WALK_PARAMS_LSB +: 8] <= param_cnt_q;
                rd_data_q[ptab_pkg::WALK_PADS_LSB +: 8] <= pad_cnt_q;
                rd_data_q[ptab_pkg::WALK_LOC_LSB +: 16] <= sfdp_loc_q;
            end
        end
    end

    // table bytes: E7h, FFh, EAh (ddr bit 19), FFh, then density LSB first

    assign rd_data = rd_data_q;

endmodule // flash_parameter_table_rom

// *** dv/flash_parameter_table_rom_properties.sv ***
module flash_parameter_table_rom_properties #(
    parameter int ADDR_W = ptab_pkg::BUS_ADDR_W,
    parameter bit DDR_SUPPORT = ptab_pkg::DDR_SUPPORT_DEF
) (
    // clock and reset
    input wire logic clock,
    input wire logic reset,
    // register port
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [31:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [31:0] rd_data
);
    timeunit 1ns;
    timeprecision 100ps;

    // ------------------------------------------------------------
    // shadow of pointer and control
    // ------------------------------------------------------------
    logic [15:0] ptr_q;
    logic space_q;
    logic autoinc_q;

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            space_q <= 1'b0;
            autoinc_q <= 1'b1;
        end else if (wr_en && addr == ptab_pkg::REG_CTRL) begin
            space_q <= wr_data[0];
            autoinc_q <= wr_data[1];
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            ptr_q <= 16'h0000;
        end else if (wr_en && addr == ptab_pkg::REG_PTR) begin
            ptr_q <= wr_data[15:0];
        end else if (wr_en && addr == ptab_pkg::REG_CTRL && wr_data[0] != space_q) begin
            ptr_q <= wr_data[0] ? 16'h1120 : 16'h0000;
        end else if (rd_en && autoinc_q && addr == ptab_pkg::REG_DATA) begin
            ptr_q <= ptr_q + 16'h0001;
        end else if (rd_en && autoinc_q && addr == ptab_pkg::REG_DWORD) begin
            ptr_q <= ptr_q + 16'h0004;
        end
    end

    function automatic logic [7:0] exp_byte(input logic sp, input logic [15:0] p);
        logic [15:0] t;
        t = sp ? p - 16'h1120 : p - 16'h0016;
        if (!sp && (p == 16'h0000 || p == 16'h0011)) return 8'hF0;
        if (!sp && p == 16'h0001) return 8'h0F;
        if (!sp && p == 16'h0012) return 8'h01;
        if (!sp && p == 16'h0014) return 8'hA5;
        if (!sp && p == 16'h0015) return 8'h50;
        if (t > 16'h0007) return 8'hFF;
        if (t[2:0] == 3'h0) return 8'hE7;
        if (t[2:0] == 3'h2) return DDR_SUPPORT ? 8'hEA : 8'hE2;
        if (t[2:0] == 3'h7) return 8'h3F;
        return 8'hFF;
    endfunction

    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    sequence s_read(logic [7:0] a);
        rd_en && addr == a;
    endsequence

    sequence s_map_at(logic [15:0] p);
        s_read(ptab_pkg::REG_DATA) ##0 (!space_q && ptr_q == p);
    endsequence

    AST_RD_HOLD: assert property (!rd_en |=> $stable(rd_data))
        else $error("read data changed without a read");
    AST_UNMAPPED: assert property (rd_en && !(addr inside {8'h00, 8'h04, 8'h08, 8'h0C,
        8'h10, 8'h14}) |=> rd_data == 32'h0000_0000)
        else $error("unmapped read not zero");
    AST_CTRL_READ: assert property (s_read(ptab_pkg::REG_CTRL) |=>
        rd_data[2:0] == {1'b0, $past(autoinc_q), $past(space_q)})
        else $error("control readback wrong");
    AST_PTR_READ: assert property (s_read(ptab_pkg::REG_PTR) |=>
        rd_data[15:0] == $past(ptr_q))
        else $error("pointer readback wrong");
    AST_PAD_ID: assert property ((s_map_at(16'h0000) or s_map_at(16'h0011)) |=>
        rd_data[7:0] == 8'hF0)
        else $error("padding id wrong");
    AST_PAD_LEN: assert property (s_map_at(16'h0001) |=> rd_data[7:0] == 8'h0F)
        else $error("padding length wrong");
    AST_SFDP_ID: assert property (s_map_at(16'h0014) |=> rd_data[7:0] == 8'hA5)
        else $error("discoverable block id wrong");
    AST_SFDP_LEN: assert property (s_map_at(16'h0015) |=> rd_data[7:0] == 8'h50)
        else $error("discoverable block length wrong");
    AST_MAP_BYTE: assert property (s_read(ptab_pkg::REG_DATA) |=> rd_data[7:0] ==
        exp_byte($past(space_q), $past(ptr_q)))
        else $error("byte read wrong");
    AST_DWORD: assert property (s_read(ptab_pkg::REG_DWORD) |=> rd_data == {
        exp_byte($past(space_q), $past(ptr_q) + 16'h0003),
        exp_byte($past(space_q), $past(ptr_q) + 16'h0002),
        exp_byte($past(space_q), $past(ptr_q) + 16'h0001),
        exp_byte($past(space_q), $past(ptr_q))})
        else $error("dword read wrong");
endmodule // flash_parameter_table_rom_properties

// *** dv/ptab_host_model.sv ***
module ptab_host_model (
    // clock
    input wire logic clock,
    // register port
    output logic [ptab_pkg::BUS_ADDR_W-1:0] addr,
    output logic [31:0] wr_data,
    output logic wr_en,
    output logic rd_en,
    input wire logic [31:0] rd_data
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        addr = 8'h00;
        wr_data = 32'h0000_0000;
        wr_en = 1'b0;
        rd_en = 1'b0;
    end

    // released lines show the inverse of the last value
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge clock);
        wr_en <= 1'b0;
        addr <= ~a;
        wr_data <= ~d;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clock);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clock);
        rd_en <= 1'b0;
        addr <= ~a;
        #1 d = rd_data;
    endtask

    // follows the chain by id and length bytes
    task automatic walk_chain(output logic [7:0] n, output logic [7:0] pads,
                              output logic [15:0] loc);
        logic [15:0] p;
        logic [31:0] id;
        logic [31:0] len;
        n = 8'h00;
        pads = 8'h00;
        loc = 16'hFFFF;
        p = 16'h0000;
        wr(ptab_pkg::REG_CTRL, 32'h0000_0002);
        repeat (8) begin
            wr(ptab_pkg::REG_PTR, {16'h0000, p});
            rd(ptab_pkg::REG_DATA, id);
            if (id[7:0] == 8'hFF) break;
            rd(ptab_pkg::REG_DATA, len);
            n = n + 8'h01;
            if (id[7:0] == 8'hF0) pads = pads + 8'h01;
            if (id[7:0] == 8'hA5) loc = p;
            p = p + 16'h0001 + {8'h00, len[7:0]} + 16'h0001;
        end
    endtask
endmodule // ptab_host_model

// *** dv/flash_parameter_table_rom_test.sv ***
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin fail_count++; \
    $display("unexpected %s: expected %h, seen %h", nm, e, g); end end

module flash_parameter_table_rom_test;
    timeunit 1ns;
    timeprecision 100ps;

    localparam logic [63:0] TABLE_BYTES = 64'h3FFF_FFFF_FFEA_FFE7;
    logic clock;
    logic reset;
    logic [7:0] addr;
    logic [31:0] wr_data;
    logic wr_en;
    logic rd_en;
    logic [31:0] rd_data;
    int fail_count = 0;
    int checks_done = 0;

    flash_parameter_table_rom #(.ADDR_W(8), .WALK_MAX(16), .DDR_SUPPORT(1'b1)) dut_u (
        .clock(clock), .reset(reset), .addr(addr), .wr_data(wr_data),
        .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data));
    ptab_host_model host_u (
        .clock(clock), .addr(addr), .wr_data(wr_data),
        .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data));

    function automatic logic [7:0] map_byte(input logic [15:0] p);
        if (p == 16'h0000 || p == 16'h0011) return 8'hF0;
        if (p == 16'h0001) return 8'h0F;
        if (p == 16'h0012) return 8'h01;
        if (p == 16'h0014) return 8'hA5;
        if (p == 16'h0015) return 8'h50;
        if (p >= 16'h0016 && p <= 16'h001D) return TABLE_BYTES[(p - 16'h0016) * 8 +: 8];
        return 8'hFF;
    endfunction

    task automatic final_report();
        $display("checks %0d, mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    initial begin
        repeat (5000) @(posedge clock);
        fail_count++;
        final_report();
    end

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        logic [31:0] d;
        logic [7:0] n;
        logic [7:0] pads;
        logic [15:0] loc;
        reset = 1'b1;
        repeat (20) @(posedge clock);
        reset <= 1'b0;
        host_u.rd(ptab_pkg::REG_CTRL, d);
        `CHK("ctrl reset", 32'h0000_0002, d)
        host_u.rd(ptab_pkg::REG_PTR, d);
        `CHK("ptr reset", 16'h0000, d[15:0])
        host_u.rd(ptab_pkg::REG_WALK, d);
        `CHK("walk reset", 32'hFFFF_0000, d)
        $display("test reset values done");
        for (int i = 0; i < 16'h0067; i++) begin
            host_u.rd(ptab_pkg::REG_DATA, d);
            `CHK("map byte", map_byte(16'(i)), d[7:0])
        end
        host_u.rd(ptab_pkg::REG_STATUS, d);
        `CHK("overrun flag", 4'h8, d[3:0])
        host_u.wr(ptab_pkg::REG_STATUS, 32'h0000_0008);
        host_u.rd(ptab_pkg::REG_STATUS, d);
        `CHK("overrun clear", 4'h0, d[3:0])
        $display("test map scan done");
        host_u.wr(ptab_pkg::REG_CTRL, 32'h0000_0003);
        host_u.rd(ptab_pkg::REG_PTR, d);
        `CHK("table ptr", 16'h1120, d[15:0])
        host_u.rd(ptab_pkg::REG_DWORD, d);
        `CHK("first dword", TABLE_BYTES[31:0], d)
        host_u.rd(ptab_pkg::REG_DWORD, d);
        `CHK("second dword", TABLE_BYTES[63:32], d)
        host_u.rd(ptab_pkg::REG_DWORD, d);
        `CHK("past table", 32'hFFFF_FFFF, d)
        host_u.wr(ptab_pkg::REG_CTRL, 32'h0000_0001);
        host_u.wr(ptab_pkg::REG_PTR, 32'h0000_1122);
        repeat (2) begin
            host_u.rd(ptab_pkg::REG_DATA, d);
            `CHK("fixed byte", 8'hEA, d[7:0])
        end
        host_u.wr(ptab_pkg::REG_CTRL, 32'h0000_0000);
        host_u.rd(ptab_pkg::REG_DATA, d);
        `CHK("map restart", 8'hF0, d[7:0])
        $display("test table space done");
        host_u.wr(ptab_pkg::REG_STATUS, 32'h0000_000D);
        host_u.wr(ptab_pkg::REG_DATA, 32'h0000_0000);
        host_u.wr(ptab_pkg::REG_DWORD, 32'h0000_0000);
        host_u.wr(8'h18, 32'h0000_0055);
        host_u.rd(8'h18, d);
        `CHK("unmapped read", 32'h0000_0000, d)
        host_u.rd(ptab_pkg::REG_STATUS, d);
        `CHK("refused flag", 1'b1, d[0])
        host_u.wr(ptab_pkg::REG_PTR, 32'h0000_0014);
        host_u.rd(ptab_pkg::REG_DATA, d);
        `CHK("after refused", 8'hA5, d[7:0])
        $display("test refused writes done");
        host_u.wr(ptab_pkg::REG_CTRL, 32'h0000_0006);
        d = 32'h0000_0002;
        repeat (40) begin
            if (d[1] !== 1'b0) host_u.rd(ptab_pkg::REG_STATUS, d);
        end
        `CHK("walk idle", 1'b0, d[1])
        `CHK("walk done", 1'b1, d[2])
        host_u.rd(ptab_pkg::REG_WALK, d);
        `CHK("walk result", 32'h0014_0203, d)
        host_u.walk_chain(n, pads, loc);
        `CHK("chain count", 8'h03, n)
        `CHK("chain pads", 8'h02, pads)
        `CHK("chain block", 16'h0014, loc)
        $display("test chain walk done");
        final_report();
    end
endmodule // flash_parameter_table_rom_test

bind flash_parameter_table_rom flash_parameter_table_rom_properties #(
    .ADDR_W(ADDR_W), .DDR_SUPPORT(DDR_SUPPORT)) chk_u (
    .clock(clock), .reset(reset), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data));
